// >>> rtl/aoms_pkg.sv
package aoms_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MODE_CH0  = 6'h38;
  localparam logic [5:0] IDX_MODE_CH1  = 6'h3A;
  localparam logic [5:0] IDX_ADC_STAT  = 6'h04;
  localparam logic [5:0] IDX_CH_DATA0  = 6'h08;
  localparam logic [5:0] IDX_CH_DATA1  = 6'h09;
  localparam logic [5:0] IDX_CH_STAT0  = 6'h0C;
  localparam logic [5:0] IDX_CH_STAT1  = 6'h0D;
  localparam logic [5:0] IDX_ADC_ZS    = 6'h10;
  localparam logic [5:0] IDX_CH_ZS0    = 6'h11;
  localparam logic [5:0] IDX_CH_ZS1    = 6'h12;
  localparam logic [5:0] IDX_CH_FS0    = 6'h13;
  localparam logic [5:0] IDX_CH_FS1    = 6'h14;
  localparam logic [5:0] IDX_IRQ_STAT  = 6'h20;
  localparam logic [5:0] IDX_IRQ_MASK  = 6'h21;
  localparam logic [5:0] IDX_CH_SETUP0 = 6'h28;
  localparam logic [5:0] IDX_CH_SETUP1 = 6'h29;
  localparam logic [5:0] IDX_CONV_T0   = 6'h30;
  localparam logic [5:0] IDX_CONV_T1   = 6'h31;

  // Mode register fields
  localparam int          MODE_FIELD_LSB   = 5;
  localparam int          CLK_OUT_DIS_BIT  = 4;
  localparam logic [7:0]  MODE_RESET       = 8'h00;

  // op_mode_field codes
  localparam logic [2:0] MD_IDLE    = 3'h0;
  localparam logic [2:0] MD_CONT    = 3'h1;
  localparam logic [2:0] MD_SINGLE  = 3'h2;
  localparam logic [2:0] MD_STANDBY = 3'h3;
  localparam logic [2:0] MD_SELF_ZS = 3'h4;
  localparam logic [2:0] MD_RSVD    = 3'h5;
  localparam logic [2:0] MD_SYS_ZS  = 3'h6;
  localparam logic [2:0] MD_SYS_FS  = 3'h7;

  // Setup and timing
  localparam int          SETUP_EN_BIT    = 0;
  localparam logic [7:0]  SETUP_RESET     = 8'h01;
  localparam logic [15:0] CONV_T_RESET    = 16'h0010;

  // Interrupt status bit positions
  localparam int IRQ_CONV_BIT = 0;
  localparam int IRQ_CAL_BIT  = 1;

  localparam int NUM_CH = 2;

  typedef enum logic [1:0] {
    AOMS_IDLE,
    AOMS_CONV,
    AOMS_CAL,
    AOMS_STANDBY
  } aoms_state_t;

endpackage

// >>> rtl/aoms_sequencer.sv
`timescale 1ns/1ns
// Overview of operation
// R1: Decode three-bit mode field into eight modes
// R2: Reset enters idle with mode field zero
// R3: Calibration or single conversion self-returns to idle
// R4: Continuous: convert channel, update, flag, advance
// R5: Continuous cycling continues until mode change/reset
// R6: Cycle period sums enabled channels' conversion times
// R7: Single done: update result, flag, ready low
// R8: Single conversion ignores channel enable bit
// R9: Standby powers converter down, bus stays live
// R10: Clock output governed only by disable bit
// R11: Self zero-scale writes converter calibration register
// R12: Calibration end sets both ready flags, ready low
// R13: System zero-scale stores channel zero-scale register
// R14: System full-scale stores channel full-scale register
// R15: Mode write clears status, ready high, restarts
// R16: Index bit one selects channel; reads lower
// R17: Reserved mode code behaves like idle
module aoms_sequencer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irq_o,
  input  wire logic        mclk_i,
  input  wire logic [23:0] adc_sample_i,
  output logic             ready_n_o,
  output logic             afe_power_down_o,
  output logic             master_clock_output_o,
  output logic             master_clock_output_oe_n_o
);

  logic [7:0]  mode;
  logic        cur_ch;
  logic [2:0]  op_mode_field;
  logic        clock_out_disable;
  aoms_pkg::aoms_state_t state;

  logic [15:0] cnt;
  logic [15:0] conv_t [aoms_pkg::NUM_CH];
  logic [7:0]  setup  [aoms_pkg::NUM_CH];
  logic [23:0] data   [aoms_pkg::NUM_CH];
  logic [7:0]  ch_stat[aoms_pkg::NUM_CH];
  logic [23:0] ch_zs  [aoms_pkg::NUM_CH];
  logic [23:0] ch_fs  [aoms_pkg::NUM_CH];
  logic [23:0] adc_zs;
  logic [aoms_pkg::NUM_CH-1:0] ready;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;

  logic        mclk_s1;
  logic        mclk_s2;
  logic        mclk_s3;
  logic [23:0] smp_s1;
  logic [23:0] smp_s2;
  logic [23:0] smp_s3;
  logic [23:0] smp_held;

  logic [5:0]  idx;
  logic        bus_req;
  logic        wr_acc;
  logic        rd_acc;
  logic        mode_wr;
  logic        mclk_edge;
  logic [15:0] ct_eff;
  logic        done;
  logic        conv_done;
  logic        cal_done;
  logic        next_ch;
  logic [31:0] next_dat;

  assign op_mode_field     = mode[aoms_pkg::MODE_FIELD_LSB +: 3];
  assign clock_out_disable = mode[aoms_pkg::CLK_OUT_DIS_BIT];
  assign idx       = adr_i[7:2];
  assign bus_req   = cyc_i && stb_i && !ack_o;
  assign wr_acc    = bus_req && we_i;
  assign rd_acc    = bus_req && !we_i;
  assign mode_wr   = wr_acc && sel_i[0] &&
                     (idx == aoms_pkg::IDX_MODE_CH0 || idx == aoms_pkg::IDX_MODE_CH1);
  assign mclk_edge = mclk_s2 && !mclk_s3;
  assign ct_eff    = (conv_t[cur_ch] == 16'h0000) ? 16'h0001 : conv_t[cur_ch];
  // Each operation lasts the selected channel's conversion time
  assign done      = mclk_edge && !mode_wr && ({1'b0, cnt} + 17'h00001 >= {1'b0, ct_eff}); // R6
  assign conv_done = done && state == aoms_pkg::AOMS_CONV;
  assign cal_done  = done && state == aoms_pkg::AOMS_CAL;
  // Other channel if enabled, else stay on the current one
  assign next_ch   = setup[~cur_ch][aoms_pkg::SETUP_EN_BIT] ? ~cur_ch : cur_ch; // R4

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Link clock and converter data cross in two flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mclk_s1 <= 1'b0;
      mclk_s2 <= 1'b0;
      mclk_s3 <= 1'b0;
      smp_s1  <= 24'h000000;
      smp_s2  <= 24'h000000;
    end else begin
      mclk_s1 <= mclk_i;
      mclk_s2 <= mclk_s1;
      mclk_s3 <= mclk_s2;
      smp_s1  <= adc_sample_i;
      smp_s2  <= smp_s1;
    end
  end

  // Converter word is taken only once two synchronised samples agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smp_s3   <= 24'h000000;
      smp_held <= 24'h000000;
    end else begin
      smp_s3 <= smp_s2;
      if (smp_s2 == smp_s3) begin
        smp_held <= smp_s2;
      end
    end
  end

  // Bus handshake: ack one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  always_comb begin
    next_dat = 32'h00000000;
    unique case (idx)
      aoms_pkg::IDX_MODE_CH0:  next_dat = {24'h000000, mode}; // R16
      aoms_pkg::IDX_ADC_STAT:  next_dat = {30'h00000000, ready};
      aoms_pkg::IDX_CH_DATA0:  next_dat = {8'h00, data[0]};
      aoms_pkg::IDX_CH_DATA1:  next_dat = {8'h00, data[1]};
      aoms_pkg::IDX_CH_STAT0:  next_dat = {24'h000000, ch_stat[0]};
      aoms_pkg::IDX_CH_STAT1:  next_dat = {24'h000000, ch_stat[1]};
      aoms_pkg::IDX_ADC_ZS:    next_dat = {8'h00, adc_zs};
      aoms_pkg::IDX_CH_ZS0:    next_dat = {8'h00, ch_zs[0]};
      aoms_pkg::IDX_CH_ZS1:    next_dat = {8'h00, ch_zs[1]};
      aoms_pkg::IDX_CH_FS0:    next_dat = {8'h00, ch_fs[0]};
      aoms_pkg::IDX_CH_FS1:    next_dat = {8'h00, ch_fs[1]};
      aoms_pkg::IDX_IRQ_STAT:  next_dat = {30'h00000000, irq_stat};
      aoms_pkg::IDX_IRQ_MASK:  next_dat = {30'h00000000, irq_mask};
      aoms_pkg::IDX_CH_SETUP0: next_dat = {24'h000000, setup[0]};
      aoms_pkg::IDX_CH_SETUP1: next_dat = {24'h000000, setup[1]};
      aoms_pkg::IDX_CONV_T0:   next_dat = {16'h0000, conv_t[0]};
      aoms_pkg::IDX_CONV_T1:   next_dat = {16'h0000, conv_t[1]};
      default:                 next_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (rd_acc) begin
      dat_o <= next_dat;
    end
  end

  // Software settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= 2'h0;
      for (int c = 0; c < aoms_pkg::NUM_CH; c++) begin
        setup[c]  <= aoms_pkg::SETUP_RESET;
        conv_t[c] <= aoms_pkg::CONV_T_RESET;
      end
    end else if (wr_acc) begin
      unique case (idx)
        aoms_pkg::IDX_IRQ_MASK:  irq_mask  <= sel_i[0] ? dat_i[1:0] : irq_mask;
        aoms_pkg::IDX_CH_SETUP0: setup[0]  <= sel_i[0] ? dat_i[7:0] : setup[0];
        aoms_pkg::IDX_CH_SETUP1: setup[1]  <= sel_i[0] ? dat_i[7:0] : setup[1];
        aoms_pkg::IDX_CONV_T0:   conv_t[0] <= 16'(merge({16'h0000, conv_t[0]}, dat_i, sel_i));
        aoms_pkg::IDX_CONV_T1:   conv_t[1] <= 16'(merge({16'h0000, conv_t[1]}, dat_i, sel_i));
        default: ;
      endcase
    end
  end

  // Mode register and sequencer state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode   <= aoms_pkg::MODE_RESET; // R2
      cur_ch <= 1'b0;
      state  <= aoms_pkg::AOMS_IDLE; // R2
      cnt    <= 16'h0000;
    end else if (mode_wr) begin
      mode   <= dat_i[7:0];
      cur_ch <= idx[1]; // R16
      cnt    <= 16'h0000; // R15
      unique case (dat_i[aoms_pkg::MODE_FIELD_LSB +: 3]) // R1
        aoms_pkg::MD_CONT, aoms_pkg::MD_SINGLE: state <= aoms_pkg::AOMS_CONV; // R8
        aoms_pkg::MD_STANDBY: state <= aoms_pkg::AOMS_STANDBY;
        aoms_pkg::MD_SELF_ZS, aoms_pkg::MD_SYS_ZS, aoms_pkg::MD_SYS_FS:
          state <= aoms_pkg::AOMS_CAL;
        aoms_pkg::MD_IDLE, aoms_pkg::MD_RSVD: state <= aoms_pkg::AOMS_IDLE; // R17
      endcase
    end else if (done && (state == aoms_pkg::AOMS_CONV || state == aoms_pkg::AOMS_CAL)) begin
      cnt <= 16'h0000;
      if (state == aoms_pkg::AOMS_CONV && op_mode_field == aoms_pkg::MD_CONT) begin
        cur_ch <= next_ch; // R5
      end else begin
        mode[aoms_pkg::MODE_FIELD_LSB +: 3] <= aoms_pkg::MD_IDLE; // R3
        state <= aoms_pkg::AOMS_IDLE; // R3
      end
    end else if (mclk_edge && (state == aoms_pkg::AOMS_CONV || state == aoms_pkg::AOMS_CAL)) begin
      cnt <= cnt + 16'h0001;
    end
  end

  // Results and calibration coefficients
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_zs <= 24'h000000;
      for (int c = 0; c < aoms_pkg::NUM_CH; c++) begin
        data[c]    <= 24'h000000;
        ch_stat[c] <= 8'h00;
        ch_zs[c]   <= 24'h000000;
        ch_fs[c]   <= 24'h000000;
      end
    end else if (conv_done) begin
      data[cur_ch]    <= smp_held; // R4 R7
      ch_stat[cur_ch] <= {op_mode_field, 4'h0, cur_ch}; // R4 R7
    end else if (cal_done) begin
      unique case (op_mode_field)
        aoms_pkg::MD_SELF_ZS: adc_zs        <= smp_held; // R11
        aoms_pkg::MD_SYS_ZS:  ch_zs[cur_ch] <= smp_held; // R13
        aoms_pkg::MD_SYS_FS:  ch_fs[cur_ch] <= smp_held; // R14
        default: ;
      endcase
    end
  end

  // Per-channel ready flags; a new result beats a clearing read
  generate
    for (genvar c = 0; c < aoms_pkg::NUM_CH; c++) begin : g_rdy
      logic data_rd;
      assign data_rd = rd_acc && idx == (c == 0 ? aoms_pkg::IDX_CH_DATA0 : aoms_pkg::IDX_CH_DATA1);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ready[c] <= 1'b0;
        end else if ((conv_done && cur_ch == c) || cal_done) begin
          ready[c] <= 1'b1; // R4 R7 R12
        end else if (mode_wr || data_rd) begin
          ready[c] <= 1'b0; // R15
        end
      end
    end
  endgenerate

  // Sticky events, cleared by reading, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 2'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if ((b == aoms_pkg::IRQ_CONV_BIT && conv_done) || (b == aoms_pkg::IRQ_CAL_BIT && cal_done)) begin
          irq_stat[b] <= 1'b1;
        end else if (rd_acc && idx == aoms_pkg::IDX_IRQ_STAT) begin
          irq_stat[b] <= 1'b0;
        end
      end
    end
  end

  // Pin outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o                      <= 1'b0;
      ready_n_o                  <= 1'b1;
      afe_power_down_o           <= 1'b0;
      master_clock_output_o      <= 1'b0;
      master_clock_output_oe_n_o <= 1'b0;
    end else begin
      irq_o                      <= |(irq_stat & irq_mask);
      ready_n_o                  <= ~|ready; // R7 R12 R15
      afe_power_down_o           <= state == aoms_pkg::AOMS_STANDBY; // R9
      master_clock_output_o      <= mclk_s2; // R10
      master_clock_output_oe_n_o <= clock_out_disable; // R10
    end
  end

endmodule

// >>> verif/aoms_conv_model.sv
`timescale 1ns/1ns
module aoms_conv_model (
  input  wire logic [23:0] value_i,
  output logic             mclk_o,
  output logic [23:0]      sample_o
);
  // Free-running master clock, phase unrelated to the bus clock
  initial begin
    mclk_o = 1'b0;
    #3;
    forever #32 mclk_o = ~mclk_o;
  end
  assign sample_o = value_i;
endmodule

// >>> verif/aoms_sequencer_asserts.sv
`timescale 1ns/1ns
module aoms_sequencer_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        irq_o,
  input wire logic        mclk_i,
  input wire logic [23:0] adc_sample_i,
  input wire logic        ready_n_o,
  input wire logic        afe_power_down_o,
  input wire logic        master_clock_output_o,
  input wire logic        master_clock_output_oe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       take;
  logic       mode_wr;
  logic [2:0] wr_code;
  logic       wr_dis;
  assign take    = cyc_i && stb_i && !ack_o;
  assign mode_wr = take && we_i && sel_i[0]
                   && (adr_i[7:2] inside {aoms_pkg::IDX_MODE_CH0, aoms_pkg::IDX_MODE_CH1});
  always_ff @(posedge clk_i) begin
    if (mode_wr) begin
      wr_code <= dat_i[7:5];
      wr_dis  <= dat_i[4];
    end
  end
  sequence s_mode_take;
    mode_wr;
  endsequence
  property p_ack_resp; take |=> ack_o; endproperty
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  property p_reset;
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> ready_n_o && !ack_o && !irq_o && !afe_power_down_o;
  endproperty
  property p_ready_high; s_mode_take |-> ##[2:4] ready_n_o; endproperty
  property p_standby;
    s_mode_take |-> ##3 (afe_power_down_o == (wr_code == aoms_pkg::MD_STANDBY));
  endproperty
  property p_clk_dis; s_mode_take |-> ##3 (master_clock_output_oe_n_o == wr_dis); endproperty
  property p_clk_follow; $rose(master_clock_output_o) |-> $past(mclk_i, 3); endproperty
  property p_inactive;
    s_mode_take ##0 (dat_i[7:5] inside {3'h0, 3'h5}) |-> ##4 ready_n_o [*8];
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  a_reset: assert property (p_reset) else $error("reset outputs");
  a_ready_high: assert property (p_ready_high) else $error("ready not high");
  a_standby: assert property (p_standby) else $error("power down wrong");
  a_clk_dis: assert property (p_clk_dis) else $error("clock enable wrong");
  a_clk_follow: assert property (p_clk_follow) else $error("clock out wrong");
  a_inactive: assert property (p_inactive) else $error("op started");
endmodule
bind aoms_sequencer aoms_sequencer_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .irq_o, .mclk_i, .adc_sample_i, .ready_n_o,
  .afe_power_down_o, .master_clock_output_o, .master_clock_output_oe_n_o);

// >>> verif/aoms_sequencer_test.sv
`timescale 1ns/1ns
module aoms_sequencer_test;
  logic        clk_i      = 1'b0;
  logic        rst_i      = 1'b1;
  logic        cyc_i      = 1'b0;
  logic        stb_i      = 1'b0;
  logic        we_i       = 1'b0;
  logic [7:0]  adr_i      = 8'h00;
  logic [3:0]  sel_i      = 4'hF;
  logic [31:0] dat_i      = 32'h0;
  logic [23:0] value      = 24'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        irq_o;
  logic        mclk;
  logic [23:0] sample;
  logic        ready_n_o;
  logic        afe_power_down_o;
  logic        mclk_out;
  logic        mclk_oe_n;
  logic [31:0] rd;
  integer      seed       = 51665;
  integer      fail_count = 0;
  integer      checks     = 0;
  always #4 clk_i = ~clk_i;
  aoms_conv_model conv (.value_i(value), .mclk_o(mclk), .sample_o(sample));
  aoms_sequencer uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .irq_o, .mclk_i(mclk), .adc_sample_i(sample), .ready_n_o, .afe_power_down_o,
    .master_clock_output_o(mclk_out), .master_clock_output_oe_n_o(mclk_oe_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    rd = dat_o;
    chk(n, 2, "ack latency");
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    while (ready_n_o !== 1'b0 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  function automatic logic [5:0] res_idx(input logic [2:0] c, input logic h);
    case (c)
      aoms_pkg::MD_SINGLE: return aoms_pkg::IDX_CH_DATA0 + 6'(h);
      aoms_pkg::MD_SELF_ZS: return aoms_pkg::IDX_ADC_ZS;
      aoms_pkg::MD_SYS_ZS: return aoms_pkg::IDX_CH_ZS0 + 6'(h);
      default: return aoms_pkg::IDX_CH_FS0 + 6'(h);
    endcase
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    logic [2:0]  code;
    logic        ch;
    logic [1:0]  mask;
    logic [1:0]  ev;
    logic [31:0] m;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, aoms_pkg::IDX_MODE_CH0, 0);
    chk(rd, 0, "mode after reset");
    bus(0, aoms_pkg::IDX_MODE_CH1, 0);
    chk(rd, 0, "upper mode read");
    bus(0, 6'h3F, 0);
    chk(rd, 0, "unmapped read");
    bus(1, aoms_pkg::IDX_CONV_T0, 32'h2);
    bus(1, aoms_pkg::IDX_CONV_T1, 32'h3);
    for (int i = 0; i < 16; i++) begin
      code = 3'(i);
      ch = 1'($random(seed));
      mask = 2'($random(seed));
      value <= 24'($random(seed));
      m = {24'h0, code, 5'($random(seed))};
      bus(0, aoms_pkg::IDX_IRQ_STAT, 0);
      bus(1, aoms_pkg::IDX_IRQ_MASK, {30'h0, mask});
      bus(1, aoms_pkg::IDX_CH_SETUP0 + 6'(ch), {31'h0, code != aoms_pkg::MD_SINGLE});
      bus(1, aoms_pkg::IDX_CH_SETUP0 + 6'(!ch), 32'h1);
      bus(1, ch ? aoms_pkg::IDX_MODE_CH1 : aoms_pkg::IDX_MODE_CH0, m);
      bus(0, aoms_pkg::IDX_ADC_STAT, 0);
      chk(rd[1:0], 2'b00, "status after mode write");
      chk(ready_n_o, 1'b1, "ready after mode write");
      case (code)
        aoms_pkg::MD_SINGLE, aoms_pkg::MD_SELF_ZS, aoms_pkg::MD_SYS_ZS, aoms_pkg::MD_SYS_FS: begin
          wait_rdy();
          chk(ready_n_o, 1'b0, "ready at end");
          bus(0, aoms_pkg::IDX_MODE_CH0, 0);
          chk(rd[7:5], 3'h0, "mode field at end");
          bus(0, aoms_pkg::IDX_ADC_STAT, 0);
          ev = (code == aoms_pkg::MD_SINGLE) ? 2'b01 : 2'b10;
          chk(rd[1:0], (code == aoms_pkg::MD_SINGLE) ? 2'(1 << ch) : 2'b11, "flags");
          chk(irq_o, |(ev & mask), "irq level");
          bus(0, aoms_pkg::IDX_IRQ_STAT, 0);
          chk(rd[1:0], ev, "irq status");
          bus(0, res_idx(code, ch), 0);
          chk(rd[23:0], value, "result");
          chk(irq_o, 1'b0, "irq after clear");
        end
        aoms_pkg::MD_CONT: begin
          repeat (24) @(posedge clk_i);
          bus(0, aoms_pkg::IDX_ADC_STAT, 0);
          chk(rd[1:0], ch ? 2'b10 : 2'b01, "first channel");
          bus(0, aoms_pkg::IDX_CH_STAT0 + 6'(ch), 0);
          chk(rd[7:0], {aoms_pkg::MD_CONT, 4'h0, ch}, "channel status");
          repeat (40) @(posedge clk_i);
          bus(0, aoms_pkg::IDX_ADC_STAT, 0);
          chk(rd[1:0], 2'b11, "both channels");
          bus(0, aoms_pkg::IDX_MODE_CH0, 0);
          chk(rd[7:5], aoms_pkg::MD_CONT, "still cycling");
        end
        aoms_pkg::MD_STANDBY: begin
          chk(afe_power_down_o, 1'b1, "power down");
          chk(mclk_oe_n, m[4], "clock output enable");
        end
        default: begin
          repeat (40) @(posedge clk_i);
          bus(0, aoms_pkg::IDX_ADC_STAT, 0);
          chk({ready_n_o, rd[1:0]}, 3'b100, "inactive");
        end
      endcase
      $display("mode %0d on channel %0d done", code, ch);
    end
    // Reset in the middle of continuous conversion
    bus(1, aoms_pkg::IDX_MODE_CH0, 32'h00000020);
    repeat (30) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, aoms_pkg::IDX_MODE_CH0, 0);
    chk(rd, 0, "mode after second reset");
    chk(ready_n_o, 1'b1, "ready after second reset");
    $display("reset in mid-run done");
    stop_test();
  end
endmodule
